// File: common/dmac_pkg.sv
// constants and types shared by the two-channel dma controller
package dmac_pkg;
    localparam int NCH = 2;
    // register byte offsets; channel n adds n times the stride
    localparam logic [7:0] OFF_SRC = 8'h00;
    localparam logic [7:0] OFF_DST = 8'h04;
    localparam logic [7:0] OFF_CNT = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] OFF_ISTAT = 8'h40;
    localparam logic [7:0] OFF_IMASK = 8'h44;
    // channel control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_FLY = 1;
    localparam int CTRL_FLYWR = 2;
    localparam int CTRL_SSZ = 3;
    localparam int CTRL_DSZ = 5;
    localparam int CTRL_REQ = 7;
    localparam int CTRL_BW = 9;
    localparam int CTRL_IRQREL = 11;
    localparam int CTRL_SINC = 12;
    localparam int CTRL_DINC = 13;
    localparam int CTRL_W = 14;
    // status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_ZERO = 1;
    // reset values
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [13:0] CTRL_RST = 14'h3000;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // port sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // request modes
    localparam logic [1:0] REQ_INT = 2'h0;
    localparam logic [1:0] REQ_BURST = 2'h1;
    localparam logic [1:0] REQ_STEAL = 2'h2;
    // engine states, gray along idle-read-write and idle-flyby
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_WRITE = 2'h3,
        ST_FLY = 2'h2
    } dmac_state_t;
endpackage

// File: logic/dmac_top.sv
// two-channel dma controller with apb registers and external bus master
`timescale 1ns/1ps
module dmac_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // channel handshake
    input wire logic [1:0] dmaReq,
    output logic [1:0] dmaAck,
    output logic [1:0] dmaDone,
    // arbitration with the processor
    input wire logic cpuBusReq,
    input wire logic hiPrioIrqPending,
    output logic busGrantCpu,
    // external bus master
    output logic mReq,
    output logic mWrite,
    output logic [31:0] mAddr,
    output logic [1:0] mSize,
    output logic [31:0] mWdata,
    output logic mDmaCycle,
    input wire logic [31:0] mRdata,
    input wire logic mAck
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [31:0] srcAddr_q [dmac_pkg::NCH];
    logic [31:0] dstAddr_q [dmac_pkg::NCH];
    logic [31:0] count_q [dmac_pkg::NCH];
    logic [13:0] ctrl_q [dmac_pkg::NCH];
    logic [1:0] istat_q;
    logic [1:0] imask_q;
    logic [1:0] reqPrev_q;
    logic [1:0] stealPend_q;
    logic [1:0] phase_q;
    logic [31:0] data_q;
    logic curCh_q;
    dmac_pkg::dmac_state_t state_q;
    dmac_pkg::dmac_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire setupPhase = psel && !penable;
    wire wrEn = psel && penable && pwrite && pready;
    wire chBlock = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
    wire selCh = paddr[5];
    wire [7:0] regOff = {3'h0, paddr[4:0]};
    wire hitSrc = chBlock && (regOff == dmac_pkg::OFF_SRC);
    wire hitDst = chBlock && (regOff == dmac_pkg::OFF_DST);
    wire hitCnt = chBlock && (regOff == dmac_pkg::OFF_CNT);
    wire hitCtrl = chBlock && (regOff == dmac_pkg::OFF_CTRL);
    wire hitStat = chBlock && (regOff == dmac_pkg::OFF_STAT);
    wire hitIstat = (paddr == dmac_pkg::OFF_ISTAT);
    wire hitImask = (paddr == dmac_pkg::OFF_IMASK);
    wire anyHit = hitSrc || hitDst || hitCnt || hitCtrl || hitStat || hitIstat || hitImask;
    wire busyCh = (state_q != dmac_pkg::ST_IDLE) && (curCh_q == selCh);
    wire [31:0] statWord = {30'h0, count_q[selCh] == 32'h0, busyCh};
    wire [31:0] rdMux = hitSrc ? srcAddr_q[selCh] :
                        hitDst ? dstAddr_q[selCh] :
                        hitCnt ? count_q[selCh] :
                        hitCtrl ? {18'h0, ctrl_q[selCh]} :
                        hitStat ? statWord :
                        hitIstat ? {30'h0, istat_q} :
                        hitImask ? {30'h0, imask_q} : 32'h0;

    // one wait-free access phase: ready and data are loaded in the setup cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            prdata <= (setupPhase && !pwrite) ? rdMux : 32'h0;
            pslverr <= setupPhase && !anyHit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // current channel view and transfer sizing

    wire [13:0] cc = ctrl_q[curCh_q];
    wire curFly = cc[dmac_pkg::CTRL_FLY];
    wire curFlyWr = cc[dmac_pkg::CTRL_FLYWR];
    wire [1:0] curSsz = cc[dmac_pkg::CTRL_SSZ +: 2];
    wire [1:0] curDsz = cc[dmac_pkg::CTRL_DSZ +: 2];
    // a pair moves the narrower of the two ports, so no packing buffer is needed
    wire [1:0] unitSz = (curSsz < curDsz) ? curSsz : curDsz;
    wire [31:0] unitBytes = (unitSz == dmac_pkg::SZ_BYTE) ? 32'h1 :
                            (unitSz == dmac_pkg::SZ_WORD) ? 32'h2 : 32'h4;
    wire [31:0] curCnt = count_q[curCh_q];
    wire [31:0] cntNext = (curCnt > unitBytes) ? (curCnt - unitBytes) : 32'h0;
    wire xferEnd = mAck && ((state_q == dmac_pkg::ST_WRITE) || (state_q == dmac_pkg::ST_FLY));
    wire doneNow = xferEnd && (cntNext == 32'h0);

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel request qualification and registers

    // bandwidth slot: share n+1 of every four cycles is open to internal requests
    logic [1:0] want;

    genvar gi;
    generate
        for (gi = 0; gi < dmac_pkg::NCH; gi++) begin : gCh
            wire [13:0] c = ctrl_q[gi];
            wire [1:0] mode = c[dmac_pkg::CTRL_REQ +: 2];
            wire enabled = c[dmac_pkg::CTRL_EN] && (count_q[gi] != 32'h0);
            wire yield = c[dmac_pkg::CTRL_IRQREL] && hiPrioIrqPending;
            wire bwOk = (phase_q <= c[dmac_pkg::CTRL_BW +: 2]);
            wire intReq = (mode == dmac_pkg::REQ_INT) && !c[dmac_pkg::CTRL_FLY] && bwOk;
            wire burstReq = (mode == dmac_pkg::REQ_BURST) && dmaReq[gi];
            wire stealReq = (mode == dmac_pkg::REQ_STEAL) && stealPend_q[gi];
            wire mine = (curCh_q == gi);
            wire step = xferEnd && mine;
            wire dual = !c[dmac_pkg::CTRL_FLY];
            wire srcStep = step && c[dmac_pkg::CTRL_SINC] && (dual || !c[dmac_pkg::CTRL_FLYWR]);
            wire dstStep = step && c[dmac_pkg::CTRL_DINC] && (dual || c[dmac_pkg::CTRL_FLYWR]);
            wire started = (state_q == dmac_pkg::ST_IDLE || xferEnd) &&
                           (state_d != dmac_pkg::ST_IDLE) && (state_d != dmac_pkg::ST_WRITE) &&
                           (want[0] ? (gi == 0) : (gi == 1));

            assign want[gi] = enabled && !yield && (intReq || burstReq || stealReq);

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    srcAddr_q[gi] <= dmac_pkg::ADDR_RST;
                    dstAddr_q[gi] <= dmac_pkg::ADDR_RST;
                    count_q[gi] <= dmac_pkg::CNT_RST;
                    ctrl_q[gi] <= dmac_pkg::CTRL_RST;
                    reqPrev_q[gi] <= 1'b0;
                    stealPend_q[gi] <= 1'b0;
                end else begin
                    reqPrev_q[gi] <= dmaReq[gi];
                    // a new edge wins over the consuming start
                    stealPend_q[gi] <= (dmaReq[gi] && !reqPrev_q[gi]) ||
                                       (stealPend_q[gi] && !started);
                    if (wrEn && hitSrc && selCh == gi) begin
                        srcAddr_q[gi] <= pwdata;
                    end else if (srcStep) begin
                        srcAddr_q[gi] <= srcAddr_q[gi] + unitBytes;
                    end
                    if (wrEn && hitDst && selCh == gi) begin
                        dstAddr_q[gi] <= pwdata;
                    end else if (dstStep) begin
                        dstAddr_q[gi] <= dstAddr_q[gi] + unitBytes;
                    end
                    if (wrEn && hitCnt && selCh == gi) begin
                        count_q[gi] <= pwdata;
                    end else if (step) begin
                        count_q[gi] <= cntNext;
                    end
                    if (wrEn && hitCtrl && selCh == gi) begin
                        ctrl_q[gi] <= pwdata[dmac_pkg::CTRL_W-1:0];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // engine

    wire anyWant = |want;
    wire pickCh = !want[0];
    wire pickFly = ctrl_q[pickCh][dmac_pkg::CTRL_FLY];
    // the next owner is chosen while the current cycle is still running
    wire goNext = anyWant && !cpuBusReq;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dmac_pkg::ST_IDLE: begin
                if (goNext) begin
                    state_d = pickFly ? dmac_pkg::ST_FLY : dmac_pkg::ST_READ;
                end
            end
            dmac_pkg::ST_READ: begin
                if (mAck) begin
                    state_d = dmac_pkg::ST_WRITE;
                end
            end
            dmac_pkg::ST_WRITE, dmac_pkg::ST_FLY: begin
                if (mAck) begin
                    // back to back when the cpu does not wait and the count is not done, else hand over at once
                    if (goNext && !doneNow) begin
                        state_d = pickFly ? dmac_pkg::ST_FLY : dmac_pkg::ST_READ;
                    end else begin
                        state_d = dmac_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    wire loadCh = (state_q == dmac_pkg::ST_IDLE) || xferEnd;
    wire nextCh = loadCh ? pickCh : curCh_q;
    wire [13:0] nc = ctrl_q[nextCh];
    wire nFlyWr = nc[dmac_pkg::CTRL_FLYWR];
    wire nextRd = (state_d == dmac_pkg::ST_READ);
    wire nextWr = (state_d == dmac_pkg::ST_WRITE);
    wire nextFly = (state_d == dmac_pkg::ST_FLY);
    wire nextBus = state_d != dmac_pkg::ST_IDLE;
    // addresses step at the finishing edge, so a same-channel successor
    // must start from the stepped value, not the stale register
    wire sameCh = xferEnd && (nextCh == curCh_q);
    wire srcAdv = sameCh && cc[dmac_pkg::CTRL_SINC] && (!curFly || !curFlyWr);
    wire dstAdv = sameCh && cc[dmac_pkg::CTRL_DINC] && (!curFly || curFlyWr);
    wire [31:0] srcNow = srcAddr_q[nextCh] + (srcAdv ? unitBytes : 32'h0);
    wire [31:0] dstNow = dstAddr_q[nextCh] + (dstAdv ? unitBytes : 32'h0);
    // flyby drives just one address: destination when memory is written
    wire [31:0] addrD = (nextRd || (nextFly && !nFlyWr)) ? srcNow : dstNow;
    wire [1:0] sizeD = (nextWr || (nextFly && nFlyWr)) ? nc[dmac_pkg::CTRL_DSZ +: 2] :
                       nc[dmac_pkg::CTRL_SSZ +: 2];
    wire [1:0] ackD = {2{nextFly}} & (nextCh ? 2'h2 : 2'h1);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= dmac_pkg::ST_IDLE;
            curCh_q <= 1'b0;
            phase_q <= 2'h0;
            data_q <= 32'h0;
        end else begin
            state_q <= state_d;
            curCh_q <= nextCh;
            phase_q <= phase_q + 2'h1;
            if (state_q == dmac_pkg::ST_READ && mAck) begin
                data_q <= mRdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered bus, handshake and interrupt outputs

    wire [1:0] doneVec = {2{doneNow}} & (curCh_q ? 2'h2 : 2'h1);
    wire [1:0] istatClr = (wrEn && hitIstat) ? pwdata[1:0] : 2'h0;
    // a done in the clearing cycle stays set
    wire [1:0] istatD = (istat_q & ~istatClr) | doneVec;
    wire [1:0] imaskD = (wrEn && hitImask) ? pwdata[1:0] : imask_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mReq <= 1'b0;
            mWrite <= 1'b0;
            mAddr <= 32'h0;
            mSize <= dmac_pkg::SZ_BYTE;
            mWdata <= 32'h0;
            mDmaCycle <= 1'b0;
            dmaAck <= 2'h0;
            dmaDone <= 2'h0;
            busGrantCpu <= 1'b1;
            istat_q <= dmac_pkg::IRQ_RST;
            imask_q <= dmac_pkg::IRQ_RST;
            irq <= 1'b0;
        end else begin
            mReq <= nextBus;
            mWrite <= nextWr || (nextFly && nFlyWr);
            mAddr <= nextBus ? addrD : mAddr;
            mSize <= nextBus ? sizeD : mSize;
            mWdata <= (state_q == dmac_pkg::ST_READ && mAck) ? mRdata : data_q;
            mDmaCycle <= nextBus;
            dmaAck <= ackD;
            dmaDone <= doneVec;
            busGrantCpu <= !nextBus;
            istat_q <= istatD;
            imask_q <= imaskD;
            irq <= |(istatD & imaskD);
        end
    end

endmodule

// File: sim/dmac_chk_sva.sv
// port assertions for the dma controller
`timescale 1ns/1ps
module dmac_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // channels and arbitration
    input wire logic [1:0] dmaAck,
    input wire logic [1:0] dmaDone,
    input wire logic cpuBusReq,
    input wire logic busGrantCpu,
    // external bus
    input wire logic mReq,
    input wire logic mWrite,
    input wire logic [31:0] mAddr,
    input wire logic mDmaCycle,
    input wire logic mAck
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    req_hold_a: assert property (mReq && !mAck |=>
        mReq && $stable(mAddr) && $stable(mWrite))
        else $error("bus request changed before ack");
    cycle_tag_a: assert property (mReq |-> mDmaCycle)
        else $error("dma cycle without tag");
    grant_split_a: assert property (mReq |-> !busGrantCpu)
        else $error("cpu granted during dma cycle");
    read_write_a: assert property (mReq && mAck && !mWrite && dmaAck == 2'h0 |=>
        mReq && mWrite)
        else $error("read not followed by write");
    fly_ack_a: assert property (|dmaAck |-> mReq && mDmaCycle)
        else $error("ack outside a flyby cycle");
    apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    done_pulse_a: assert property (|dmaDone |=> dmaDone == 2'h0)
        else $error("done longer than one cycle");
    cpu_first_a: assert property (cpuBusReq && !mReq |=> !mReq)
        else $error("dma started over cpu request");
    cover property (mReq && mAck && mWrite);
    cover property (|dmaAck && mAck);
    cover property (|dmaDone);
endmodule
bind dmac_top dmac_chk u_chk (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pready(pready), .dmaAck(dmaAck), .dmaDone(dmaDone),
    .cpuBusReq(cpuBusReq), .busGrantCpu(busGrantCpu), .mReq(mReq), .mWrite(mWrite),
    .mAddr(mAddr), .mDmaCycle(mDmaCycle), .mAck(mAck));

// File: sim/dmac_mem_model.sv
// memory and peripheral model on the external bus
`timescale 1ns/1ps
module dmac_mem_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // bus from the controller
    input wire logic mReq,
    input wire logic mWrite,
    input wire logic [31:0] mAddr,
    // answer
    output logic [31:0] mRdata,
    output logic mAck
);
    int waitLeft;
    // random wait of zero to two cycles, so prompt and slow answers both occur
    always @(posedge ref_clk) begin
        if (reset || !mReq || mAck) begin
            mAck <= 1'b0;
            waitLeft <= $urandom % 3;
            mRdata <= reset ? 32'h0000_0000 : ~mRdata;
        end else if (waitLeft == 0) begin
            mAck <= 1'b1;
            mRdata <= mWrite ? ~mRdata : {~mAddr[15:0], mAddr[15:0]};
        end else begin
            waitLeft <= waitLeft - 1;
        end
    end
endmodule

// File: sim/test_dual_channel_dma_controller.sv
// self-checking bench for the two-channel dma controller
`timescale 1ns/1ps
module test_dual_channel_dma_controller;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, irq, cpuBusReq;
    logic hiPrioIrqPending, busGrantCpu, mReq, mWrite, mDmaCycle, mAck;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mAddr, mWdata, mRdata, lastRd;
    logic [1:0] dmaReq, dmaAck, dmaDone, mSize, expAck;
    logic [34:0] expQ[$];
    int err_total, cmp_count;
    dmac_top dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .dmaReq(dmaReq), .dmaAck(dmaAck), .dmaDone(dmaDone),
        .cpuBusReq(cpuBusReq), .hiPrioIrqPending(hiPrioIrqPending),
        .busGrantCpu(busGrantCpu), .mReq(mReq), .mWrite(mWrite), .mAddr(mAddr),
        .mSize(mSize), .mWdata(mWdata), .mDmaCycle(mDmaCycle), .mRdata(mRdata), .mAck(mAck));
    dmac_mem_model mem (.ref_clk(ref_clk), .reset(reset), .mReq(mReq), .mWrite(mWrite),
        .mAddr(mAddr), .mRdata(mRdata), .mAck(mAck));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // finished bus cycles against the planned order
    always @(posedge ref_clk) begin
        if (!reset && mReq && mAck) begin
            chk({mWrite, mSize, mAddr}, expQ.size() > 0 ? expQ.pop_front() : 35'h0);
            chk(35'(dmaAck), 35'(expAck));
            chk(35'(mDmaCycle), 35'h1);
            if (mWrite) chk(35'(mWdata), 35'(lastRd));
            else lastRd = mRdata;
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e,
                       input logic err);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge ref_clk);
        if (k == 20) begin
            chk(35'h0, 35'h1);
            print_verdict();
        end
        chk(35'(pslverr), 35'(err));
        if (!w) chk(35'(prdata), 35'(e));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    function automatic logic [31:0] cfg(input logic f, input logic [1:0] ss, ds, rq, bw,
                                        input logic rel);
        logic [31:0] c;
        c = 32'h0000_3001;
        c[dmac_pkg::CTRL_FLY] = f;
        c[dmac_pkg::CTRL_SSZ +: 2] = ss;
        c[dmac_pkg::CTRL_DSZ +: 2] = ds;
        c[dmac_pkg::CTRL_REQ +: 2] = rq;
        c[dmac_pkg::CTRL_BW +: 2] = bw;
        c[dmac_pkg::CTRL_IRQREL] = rel;
        return c;
    endfunction
    // plan cycles, then program; narrower port sets the step
    task automatic setup(input int ch, input logic [31:0] s, n, c, input logic p);
        logic [7:0] b;
        logic [1:0] ss, ds;
        int st;
        b = 8'(ch) * dmac_pkg::CH_STRIDE;
        ss = c[dmac_pkg::CTRL_SSZ +: 2];
        ds = c[dmac_pkg::CTRL_DSZ +: 2];
        st = 1 << (ss < ds ? ss : ds);
        expAck = c[dmac_pkg::CTRL_FLY] ? 2'(1 << ch) : 2'h0;
        for (int i = 0; p && i < n; i += st) begin
            expQ.push_back({1'b0, ss, s + 32'(i)});
            if (!c[1]) expQ.push_back({1'b1, ds, s + 32'h1000 + 32'(i)});
        end
        // disable first: old settings must never run against a new count
        apb(1'b1, b + dmac_pkg::OFF_CTRL, 0, 0, 1'b0);
        apb(1'b1, b + dmac_pkg::OFF_SRC, s, 0, 1'b0);
        apb(1'b1, b + dmac_pkg::OFF_DST, s + 32'h1000, 0, 1'b0);
        apb(1'b1, b + dmac_pkg::OFF_CNT, n, 0, 1'b0);
        apb(1'b1, b + dmac_pkg::OFF_CTRL, c, 0, 1'b0);
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (mReq) chk(35'h1, 35'h0);
        end
    endtask
    // cpu requests and steal edges come at random while waiting
    task automatic finish(input int ch);
        int k;
        for (k = 0; k < 3000 && dmaDone[ch] !== 1'b1; k++) begin
            cpuBusReq <= ($urandom % 5) == 0;
            dmaReq[0] <= 1'($urandom);
            @(posedge ref_clk);
        end
        cpuBusReq <= 1'b0;
        chk(35'(k < 3000), 35'h1);
        chk(35'(expQ.size()), 35'h0);
        apb(1'b0, 8'(ch) * dmac_pkg::CH_STRIDE + dmac_pkg::OFF_STAT, 0, 32'h2, 1'b0);
        apb(1'b0, dmac_pkg::OFF_ISTAT, 0, 32'(1 << ch), 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {3'h4, 1'b0, 8'h00, 32'h0};
        {dmaReq, cpuBusReq, hiPrioIrqPending, expAck, err_total, cmp_count} = 0;
        void'($urandom(89236));
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        chk(35'(busGrantCpu), 35'h1);
        apb(1'b0, dmac_pkg::OFF_CTRL, 0, 32'h3000, 1'b0);
        apb(1'b0, dmac_pkg::CH_STRIDE + dmac_pkg::OFF_CNT, 0, 0, 1'b0);
        apb(1'b0, 8'h80, 0, 0, 1'b1);
        apb(1'b1, dmac_pkg::OFF_IMASK, 32'h3, 0, 1'b0);
        setup(0, 32'h100, 32'h4, cfg(1'b1, 2'h2, 2'h2, 2'h0, 2'h3, 1'b0), 1'b0);
        quiet(30);
        apb(1'b1, dmac_pkg::OFF_CTRL, 0, 0, 1'b0);
        hiPrioIrqPending <= 1'b1;
        setup(0, 32'h200, 32'(2 * (1 + $urandom % 6)),
              cfg(1'b0, 2'h2, 2'h1, 2'h0, 2'($urandom), 1'b1), 1'b1);
        quiet(30);
        hiPrioIrqPending <= 1'b0;
        finish(0);
        chk(35'(irq), 35'h1);
        apb(1'b1, dmac_pkg::OFF_IMASK, 0, 0, 1'b0);
        apb(1'b0, dmac_pkg::OFF_IMASK, 0, 0, 1'b0);
        chk(35'(irq), 35'h0);
        apb(1'b1, dmac_pkg::OFF_ISTAT, 32'h1, 0, 1'b0);
        apb(1'b1, dmac_pkg::OFF_IMASK, 32'h3, 0, 1'b0);
        dmaReq[1] <= 1'b1;
        setup(1, 32'h4000, 32'(4 * (1 + $urandom % 4)),
              cfg(1'b1, 2'h2, 2'h2, 2'h1, 2'h0, 1'b0), 1'b1);
        finish(1);
        dmaReq[1] <= 1'b0;
        apb(1'b1, dmac_pkg::OFF_ISTAT, 32'h2, 0, 1'b0);
        setup(0, 32'h300, 32'h3, cfg(1'b0, 2'h0, 2'h0, 2'h2, 2'h0, 1'b0), 1'b1);
        finish(0);
        apb(1'b1, dmac_pkg::OFF_ISTAT, 32'h1, 0, 1'b0);
        apb(1'b0, dmac_pkg::OFF_ISTAT, 0, 0, 1'b0);
        chk(35'(irq), 35'h0);
        print_verdict();
    end
endmodule
